/* design/lsc_supply_ctrl.sv */
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "lsc_params.svh"
module lsc_supply_ctrl #(
   parameter int unsigned TICK_DIV      = `LSC_TICK_DIV,
   parameter int unsigned OL_ARM_TICKS  = `LSC_OL_ARM_TICKS,
   parameter int unsigned OL_OFF_TICKS  = `LSC_OL_OFF_TICKS,
   parameter int unsigned OL_ON_TICKS   = `LSC_OL_ON_TICKS,
   parameter int unsigned BC_ARM_TICKS  = `LSC_BC_ARM_TICKS,
   parameter int unsigned BC_OFF_TICKS  = `LSC_BC_OFF_TICKS
) (
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic [1:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   input  wire logic       ext_modulation_input,
   input  wire logic       transmit_threshold_select,
   input  wire logic       tone_detector_input,
   input  wire logic       range_select_pin,
   input  wire logic       overload_sense,
   input  wire logic       clamp_active,
   input  wire logic       back_current_sense,
   input  wire logic       temp_above_150,
   input  wire logic       temp_below_130,
   input  wire logic       power_ok,
   input  wire logic       bus_reset,
   input  wire logic       softstart_done,
   input  wire logic       cable_open,
   input  wire logic       vout_out_of_range,
   output logic            converter_clk_en,
   output logic            converter_enable,
   output logic            output_enable,
   output logic            current_clamp,
   output logic            dyn_limit_mode,
   output logic [1:0]      limit_level,
   output logic [1:0]      vout_select,
   output logic            detector_tx_threshold,
   output logic            tone_out,
   output logic            tone_detect_out_n_o,
   output logic            tone_detect_out_n_oe,
   output logic            fault_out_n_o,
   output logic            fault_out_n_oe
);
   import lsc_pkg::*;

   lsc_cfg_s   cfg_q, cfg_d;
   lsc_stat_s  stat_w;
   logic       otf_q, otf_d;
   logic [7:0] rdata_q, rdata_d;
   logic       tick_w;
   logic       int_tone_w;
   logic       ol_off_w, ol_clamp_w, ol_dyn_flag_w;
   logic       bc_off_w, bc_flag_w;
   logic       olf_w;
   logic       run_w;
   logic       ol_fault_w;
   logic       out_en_d, conv_en_d, clamp_d, tone_d, tdet_d, fault_d, txth_d;
   logic [1:0] vsel_d, lim_d;
   logic       out_en_q, conv_en_q, clamp_q, tone_q, tdet_q, fault_q, txth_q, dyn_q;
   logic [1:0] vsel_q, lim_q;

   lsc_tick_gen #(
      .TICK_DIV (TICK_DIV)
   ) u_tick (
      .clk_sys (clk_sys),
      .reset   (reset),
      .tick    (tick_w),
      .tone    (int_tone_w)
   );

   assign run_w      = cfg_q.en && !otf_q && power_ok;
   assign ol_fault_w = overload_sense;

   lsc_retry_timer #(
      .ARM_TICKS    (OL_ARM_TICKS),
      .OFF_TICKS    (OL_OFF_TICKS),
      .ON_TICKS     (OL_ON_TICKS),
      .DROP_ENDS_ON (1'b0)
   ) u_ol (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .tick     (tick_w),
      .enable   (run_w && !cfg_q.dynamic_limit_disable),
      .clear    (softstart_done),
      .fault    (ol_fault_w),
      .out_off  (ol_off_w),
      .clamp_on (ol_clamp_w),
      .flag     (ol_dyn_flag_w)
   );

   lsc_retry_timer #(
      .ARM_TICKS    (BC_ARM_TICKS),
      .OFF_TICKS    (BC_OFF_TICKS),
      .ON_TICKS     (BC_ARM_TICKS),
      .DROP_ENDS_ON (1'b1)
   ) u_bc (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .tick     (tick_w),
      .enable   (run_w),
      .clear    (softstart_done),
      .fault    (back_current_sense),
      .out_off  (bc_off_w),
      .clamp_on (),
      .flag     (bc_flag_w)
   );

   // Static mode mirrors the clamp; dynamic mode uses the retry flag.
   assign olf_w = cfg_q.dynamic_limit_disable ? (clamp_active && run_w && !softstart_done) : ol_dyn_flag_w;

   always_comb begin
      stat_w.overtemp_flag  = otf_q;
      stat_w.cabf = cable_open;
      stat_w.ouvf = vout_out_of_range;
      stat_w.overload_flag  = olf_w;
      stat_w.bcf  = bc_flag_w;
   end

   // Configuration writes; an over-temperature event overrides them.
   always_comb begin
      cfg_d = cfg_q;
      if (reg_wr) begin
         case (reg_addr)
            `LSC_IDX_TONE: begin
               cfg_d.tone_continuous_bit  = reg_wdata[`LSC_TN_ENT];
               cfg_d.modulation_source_bit = reg_wdata[`LSC_TN_MODULATION_SOURCE_BIT];
            end
            `LSC_IDX_CMD: begin
               cfg_d.dynamic_limit_disable   = reg_wdata[`LSC_CM_DCL];
               cfg_d.voltage_select_override = reg_wdata[`LSC_CM_VOLTAGE_SELECT_OVERRIDE];
               cfg_d.limit_select_high = reg_wdata[`LSC_CM_LIMIT_SELECT_HIGH];
               cfg_d.limit_select_low = reg_wdata[`LSC_CM_LIMIT_SELECT_LOW];
            end
            `LSC_IDX_CTRL: begin
               cfg_d.en   = reg_wdata[`LSC_CT_EN];
               cfg_d.upper_range_bit = reg_wdata[`LSC_CT_UPPER_RANGE_BIT];
               cfg_d.lower_range_bit = reg_wdata[`LSC_CT_LOWER_RANGE_BIT];
            end
            default: begin
               cfg_d = cfg_q;
            end
         endcase
      end
      if (temp_above_150 && !otf_q) begin
         cfg_d = `LSC_CFG_RST;
      end
   end

   // Thermal flag with hysteresis; the hot condition wins.
   always_comb begin
      otf_d = otf_q;
      if (temp_below_130) begin
         otf_d = 1'b0;
      end
      if (temp_above_150) begin
         otf_d = 1'b1;
      end
   end

   always_comb begin
      rdata_d = `LSC_RDATA_RST;
      if (reg_rd) begin
         case (reg_addr)
            `LSC_IDX_STATUS: begin
               rdata_d[`LSC_ST_OTF]  = stat_w.overtemp_flag;
               rdata_d[`LSC_ST_CABF] = stat_w.cabf;
               rdata_d[`LSC_ST_OUVF] = stat_w.ouvf;
               rdata_d[`LSC_ST_OLF]  = stat_w.overload_flag;
               rdata_d[`LSC_ST_BCF]  = stat_w.bcf;
            end
            `LSC_IDX_TONE: begin
               rdata_d[`LSC_TN_ENT]  = cfg_q.tone_continuous_bit;
               rdata_d[`LSC_TN_MODULATION_SOURCE_BIT] = cfg_q.modulation_source_bit;
               rdata_d[`LSC_TN_TTH]  = transmit_threshold_select;
            end
            `LSC_IDX_CMD: begin
               rdata_d[`LSC_CM_DCL]   = cfg_q.dynamic_limit_disable;
               rdata_d[`LSC_CM_VOLTAGE_SELECT_OVERRIDE] = cfg_q.voltage_select_override;
               rdata_d[`LSC_CM_LIMIT_SELECT_HIGH] = cfg_q.limit_select_high;
               rdata_d[`LSC_CM_LIMIT_SELECT_LOW] = cfg_q.limit_select_low;
            end
            `LSC_IDX_CTRL: begin
               rdata_d[`LSC_CT_EN]   = cfg_q.en;
               rdata_d[`LSC_CT_UPPER_RANGE_BIT] = cfg_q.upper_range_bit;
               rdata_d[`LSC_CT_LOWER_RANGE_BIT] = cfg_q.lower_range_bit;
            end
            default: begin
               rdata_d = `LSC_RDATA_RST;
            end
         endcase
      end
   end

   // Output path: power, voltage, limit, tone and open-drain pins.
   always_comb begin
      conv_en_d = run_w;
      out_en_d  = run_w && !ol_off_w && !bc_off_w;
      clamp_d   = run_w && (cfg_q.dynamic_limit_disable || ol_clamp_w);
      lim_d     = {cfg_q.limit_select_high, cfg_q.limit_select_low};
      if (cfg_q.voltage_select_override) begin
         vsel_d = {cfg_q.upper_range_bit, cfg_q.lower_range_bit};
      end else if (range_select_pin) begin
         vsel_d = {1'b1, cfg_q.upper_range_bit};
      end else begin
         vsel_d = {1'b0, cfg_q.lower_range_bit};
      end
      if (cfg_q.tone_continuous_bit) begin
         tone_d = int_tone_w;
      end else if (cfg_q.modulation_source_bit) begin
         tone_d = ext_modulation_input;
      end else begin
         tone_d = int_tone_w && ext_modulation_input;
      end
      tone_d  = tone_d && out_en_d;
      txth_d  = transmit_threshold_select;
      tdet_d  = tone_detector_input;
      fault_d = otf_q || olf_w || bc_flag_w || !power_ok || bus_reset;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfg_q     <= `LSC_CFG_RST;
         otf_q     <= 1'b0;
         rdata_q   <= `LSC_RDATA_RST;
         conv_en_q <= 1'b0;
         out_en_q  <= 1'b0;
         clamp_q   <= 1'b0;
         lim_q     <= '0;
         vsel_q    <= '0;
         tone_q    <= 1'b0;
         txth_q    <= 1'b0;
         tdet_q    <= 1'b0;
         fault_q   <= 1'b0;
         dyn_q     <= 1'b0;
      end else begin
         cfg_q     <= cfg_d;
         otf_q     <= otf_d;
         rdata_q   <= rdata_d;
         conv_en_q <= conv_en_d;
         out_en_q  <= out_en_d;
         clamp_q   <= clamp_d;
         lim_q     <= lim_d;
         vsel_q    <= vsel_d;
         tone_q    <= tone_d;
         txth_q    <= txth_d;
         tdet_q    <= tdet_d;
         fault_q   <= fault_d;
         dyn_q     <= !cfg_d.dynamic_limit_disable;
      end
   end

   assign reg_rdata             = rdata_q;
   assign converter_clk_en      = tick_w && conv_en_q;
   assign converter_enable      = conv_en_q;
   assign output_enable         = out_en_q;
   assign current_clamp         = clamp_q;
   assign dyn_limit_mode        = dyn_q;
   assign limit_level           = lim_q;
   assign vout_select           = vsel_q;
   assign detector_tx_threshold = txth_q;
   assign tone_out              = tone_q;
   assign tone_detect_out_n_o   = 1'b0;
   assign tone_detect_out_n_oe  = tdet_q;
   assign fault_out_n_o         = 1'b0;
   assign fault_out_n_oe        = fault_q;

   property p_tone_cont;
      @(posedge clk_sys) disable iff (reset)
      (cfg_q.tone_continuous_bit && out_en_d) |=> (tone_q == $past(int_tone_w));
   endproperty
   a_tone_cont: assert property (p_tone_cont) else $error("continuous tone not on output");

   property p_tone_gated;
      @(posedge clk_sys) disable iff (reset)
      (!cfg_q.tone_continuous_bit && !cfg_q.modulation_source_bit && !ext_modulation_input) |=> !tone_q;
   endproperty
   a_tone_gated: assert property (p_tone_gated) else $error("tone out while modulation input idle");

   property p_tone_ext;
      @(posedge clk_sys) disable iff (reset)
      (!cfg_q.tone_continuous_bit && cfg_q.modulation_source_bit && out_en_d) |=> (tone_q == $past(ext_modulation_input));
   endproperty
   a_tone_ext: assert property (p_tone_ext) else $error("external tone not passed through");

   property p_tone_detect;
      @(posedge clk_sys) disable iff (reset)
      tone_detector_input |=> (tone_detect_out_n_oe && !tone_detect_out_n_o);
   endproperty
   a_tone_detect: assert property (p_tone_detect) else $error("tone detect pin not pulled low");

   property p_shutdown;
      @(posedge clk_sys) disable iff (reset)
      !cfg_q.en |=> (!converter_enable && !output_enable);
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("output active while disabled");

   property p_vsel_pin;
      @(posedge clk_sys) disable iff (reset)
      (!cfg_q.voltage_select_override && range_select_pin) |=> (vout_select == {1'b1, $past(cfg_q.upper_range_bit)});
   endproperty
   a_vsel_pin: assert property (p_vsel_pin) else $error("range pin selection wrong");

   property p_vsel_reg;
      @(posedge clk_sys) disable iff (reset)
      cfg_q.voltage_select_override |=> (vout_select == {$past(cfg_q.upper_range_bit), $past(cfg_q.lower_range_bit)});
   endproperty
   a_vsel_reg: assert property (p_vsel_reg) else $error("register voltage selection wrong");

   property p_hot_clears;
      @(posedge clk_sys) disable iff (reset)
      (temp_above_150 && !otf_q) |=> (otf_q && cfg_q == `LSC_CFG_RST) ##1 !converter_enable;
   endproperty
   a_hot_clears: assert property (p_hot_clears) else $error("thermal event did not shut down and clear");

   property p_fault_pin;
      @(posedge clk_sys) disable iff (reset)
      (otf_q || bus_reset || !power_ok) |=> fault_out_n_oe;
   endproperty
   a_fault_pin: assert property (p_fault_pin) else $error("fault pin not pulled low");

   property p_static_flag;
      @(posedge clk_sys) disable iff (reset)
      (reg_rd && reg_addr == `LSC_IDX_STATUS && cfg_q.dynamic_limit_disable && run_w && !softstart_done)
      |=> (reg_rdata[`LSC_ST_OLF] == $past(clamp_active));
   endproperty
   a_static_flag: assert property (p_static_flag) else $error("static overload flag not tracking clamp");
endmodule // lsc_supply_ctrl

/* design/lsc_params.svh */
`ifndef LSC_PARAMS_SVH
`define LSC_PARAMS_SVH
`define LSC_IDX_STATUS     2'h0
`define LSC_IDX_TONE       2'h1
`define LSC_IDX_CMD        2'h2
`define LSC_IDX_CTRL       2'h3
`define LSC_ST_OTF         4
`define LSC_ST_CABF        3
`define LSC_ST_OUVF        2
`define LSC_ST_OLF         1
`define LSC_ST_BCF         0
`define LSC_TN_ENT         4
`define LSC_TN_MODULATION_SOURCE_BIT        3
`define LSC_TN_TTH         2
`define LSC_CM_DCL         4
`define LSC_CM_VOLTAGE_SELECT_OVERRIDE       3
`define LSC_CM_LIMIT_SELECT_HIGH       1
`define LSC_CM_LIMIT_SELECT_LOW       0
`define LSC_CT_EN          4
`define LSC_CT_UPPER_RANGE_BIT        1
`define LSC_CT_LOWER_RANGE_BIT        0
`define LSC_CFG_RST        9'h000
`define LSC_RDATA_RST      8'h00
`define LSC_CLK_KHZ        200000
`define LSC_TONE_HZ        22000
`define LSC_OSC_MULT       20
`define LSC_OSC_KHZ        440
`define LSC_OL_ARM_NS      23000
`define LSC_OL_OFF_US      900000
`define LSC_OL_ON_US       20000
`define LSC_BC_ARM_US      100
`define LSC_BC_OFF_US      5000
`define LSC_TICK_DIV       ((`LSC_CLK_KHZ * 1000) / (`LSC_TONE_HZ * `LSC_OSC_MULT))
`define LSC_OL_ARM_TICKS   ((`LSC_OL_ARM_NS * `LSC_OSC_KHZ + 999999) / 1000000)
`define LSC_OL_OFF_TICKS   ((`LSC_OL_OFF_US * `LSC_OSC_KHZ) / 1000)
`define LSC_OL_ON_TICKS    ((`LSC_OL_ON_US * `LSC_OSC_KHZ) / 1000)
`define LSC_BC_ARM_TICKS   ((`LSC_BC_ARM_US * `LSC_OSC_KHZ + 999) / 1000)
`define LSC_BC_OFF_TICKS   ((`LSC_BC_OFF_US * `LSC_OSC_KHZ) / 1000)
`define LSC_TONE_HALF      10
`define LSC_TMR_W          19
`define LSC_DIV_W          16
`endif

/* design/lsc_pkg.sv */
package lsc_pkg;
   typedef enum logic [1:0] {LSC_NORMAL, LSC_ARM, LSC_OFF, LSC_ON} lsc_retry_e;

   typedef struct packed {
      logic tone_continuous_bit;
      logic modulation_source_bit;
      logic dynamic_limit_disable;
      logic voltage_select_override;
      logic limit_select_high;
      logic limit_select_low;
      logic en;
      logic upper_range_bit;
      logic lower_range_bit;
   } lsc_cfg_s;

   typedef struct packed {
      logic overtemp_flag;
      logic cabf;
      logic ouvf;
      logic overload_flag;
      logic bcf;
   } lsc_stat_s;
endpackage

/* design/lsc_tick_gen.sv */
`timescale 1ns/1ps
`include "lsc_params.svh"
module lsc_tick_gen #(
   parameter int unsigned TICK_DIV = `LSC_TICK_DIV
) (
   input  wire logic clk_sys,
   input  wire logic reset,
   output logic      tick,
   output logic      tone
);
   import lsc_pkg::*;

   logic [`LSC_DIV_W-1:0] div_q, div_d;
   logic [3:0]            ph_q, ph_d;
   logic                  tick_q, tick_d;
   logic                  tone_q, tone_d;

   always_comb begin
      div_d  = div_q + 1'b1;
      tick_d = 1'b0;
      ph_d   = ph_q;
      tone_d = tone_q;
      if (div_q == `LSC_DIV_W'(TICK_DIV - 1)) begin
         div_d  = '0;
         tick_d = 1'b1;
      end
      if (tick_q) begin
         if (ph_q == 4'(`LSC_TONE_HALF - 1)) begin
            ph_d   = '0;
            tone_d = ~tone_q;
         end else begin
            ph_d = ph_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         div_q  <= '0;
         ph_q   <= '0;
         tick_q <= 1'b0;
         tone_q <= 1'b0;
      end else begin
         div_q  <= div_d;
         ph_q   <= ph_d;
         tick_q <= tick_d;
         tone_q <= tone_d;
      end
   end

   assign tick = tick_q;
   assign tone = tone_q;

   property p_tone_on_tick;
      @(posedge clk_sys) disable iff (reset)
      (tone_q != $past(tone_q)) |-> $past(tick_q, 1);
   endproperty
   a_tone_on_tick: assert property (p_tone_on_tick) else $error("tone changed without oscillator tick");
endmodule // lsc_tick_gen

/* design/lsc_retry_timer.sv */
`timescale 1ns/1ps
`include "lsc_params.svh"
module lsc_retry_timer #(
   parameter int unsigned ARM_TICKS   = 1,
   parameter int unsigned OFF_TICKS   = 1,
   parameter int unsigned ON_TICKS    = 1,
   parameter bit          DROP_ENDS_ON = 1'b0
) (
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic tick,
   input  wire logic enable,
   input  wire logic clear,
   input  wire logic fault,
   output logic      out_off,
   output logic      clamp_on,
   output logic      flag
);
   import lsc_pkg::*;

   lsc_retry_e             st_q, st_d;
   logic [`LSC_TMR_W-1:0]  cnt_q, cnt_d;
   logic                   flag_q, flag_d;
   logic                   seen_q, seen_d;

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      flag_d = flag_q;
      seen_d = seen_q;
      case (st_q)
         LSC_NORMAL: begin
            cnt_d = '0;
            if (fault) begin
               st_d = LSC_ARM;
            end
         end
         LSC_ARM: begin
            if (!fault) begin
               st_d = LSC_NORMAL;
            end else if (tick) begin
               if (cnt_q == `LSC_TMR_W'(ARM_TICKS - 1)) begin
                  st_d   = LSC_OFF;
                  cnt_d  = '0;
                  flag_d = 1'b1;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
         end
         LSC_OFF: begin
            if (tick) begin
               if (cnt_q == `LSC_TMR_W'(OFF_TICKS - 1)) begin
                  st_d   = LSC_ON;
                  cnt_d  = '0;
                  seen_d = 1'b0;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
         end
         LSC_ON: begin
            seen_d = seen_q | fault;
            if (DROP_ENDS_ON && seen_q && !fault) begin
               st_d   = LSC_NORMAL;
               flag_d = 1'b0;
            end else if (tick) begin
               if (cnt_q == `LSC_TMR_W'(ON_TICKS - 1)) begin
                  cnt_d  = '0;
                  seen_d = 1'b0;
                  if (fault) begin
                     st_d = LSC_OFF;
                  end else if (!seen_q) begin
                     st_d   = LSC_NORMAL;
                     flag_d = 1'b0;
                  end
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
         end
         default: begin
            st_d = LSC_NORMAL;
         end
      endcase
      if (!enable || clear) begin
         st_d   = LSC_NORMAL;
         cnt_d  = '0;
         flag_d = 1'b0;
         seen_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q   <= LSC_NORMAL;
         cnt_q  <= '0;
         flag_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         flag_q <= flag_d;
         seen_q <= seen_d;
      end
   end

   assign out_off  = (st_q == LSC_OFF);
   assign clamp_on = (st_q == LSC_ON);
   assign flag     = flag_q;

   property p_trip_sets_flag;
      @(posedge clk_sys) disable iff (reset)
      (st_q == LSC_ARM && tick && fault && enable && !clear && cnt_q == `LSC_TMR_W'(ARM_TICKS - 1))
      |=> (st_q == LSC_OFF && flag_q && cnt_q == '0);
   endproperty
   a_trip_sets_flag: assert property (p_trip_sets_flag) else $error("trip did not turn output off with flag");

   property p_off_to_on;
      @(posedge clk_sys) disable iff (reset)
      (st_q == LSC_OFF && tick && enable && !clear && cnt_q == `LSC_TMR_W'(OFF_TICKS - 1)) |=> (st_q == LSC_ON);
   endproperty
   a_off_to_on: assert property (p_off_to_on) else $error("off interval did not end in on interval");

   property p_flag_in_off;
      @(posedge clk_sys) disable iff (reset)
      (st_q == LSC_OFF) |-> flag_q;
   endproperty
   a_flag_in_off: assert property (p_flag_in_off) else $error("output off without flag");

   property p_drop_ends_on;
      @(posedge clk_sys) disable iff (reset)
      (DROP_ENDS_ON && st_q == LSC_ON && seen_q && !fault && enable && !clear) |=> (st_q == LSC_NORMAL && !flag_q);
   endproperty
   a_drop_ends_on: assert property (p_drop_ends_on) else $error("fault gone but retry window kept running");
endmodule // lsc_retry_timer

/* test/lsc_lnb_model.sv */
`timescale 1ns/1ps
module lsc_lnb_model (
   input  wire logic output_enable,
   input  wire logic short_load,
   input  wire logic back_feed,
   input  wire logic lnb_tone,
   output logic      overload_sense,
   output logic      clamp_active,
   output logic      back_current_sense,
   output logic      tone_detector_input
);
   // The load draws or feeds current only while the line is driven.
   assign overload_sense      = short_load & output_enable;
   assign clamp_active        = short_load & output_enable;
   assign back_current_sense  = back_feed & output_enable;
   assign tone_detector_input = lnb_tone;
endmodule // lsc_lnb_model

/* test/lsc_supply_ctrl_tb.sv */
`timescale 1ns/1ps
module lsc_supply_ctrl_tb;
   import lsc_pkg::*;
   logic       clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0;
   logic [1:0] reg_addr = 0, limit_level, vout_select;
   logic [7:0] reg_wdata = 0, reg_rdata;
   logic       ext_modulation_input = 0, transmit_threshold_select = 0, range_select_pin = 0;
   logic       temp_above_150 = 0, temp_below_130 = 0, softstart_done = 0, short_load = 0, back_feed = 0;
   logic       power_ok = 1, bus_reset = 0, cable_open = 0, vout_out_of_range = 0, lnb_tone = 0;
   logic       overload_sense, clamp_active, back_current_sense, tone_detector_input, converter_clk_en;
   logic       converter_enable, output_enable, current_clamp, dyn_limit_mode, detector_tx_threshold;
   logic       tone_out, tone_detect_out_n_o, tone_detect_out_n_oe, fault_out_n_o, fault_out_n_oe;
   int         fail_count = 0, num_checks = 0, n;
   always #2.5 clk_sys = ~clk_sys;
   lsc_supply_ctrl #(.TICK_DIV(4), .OL_ARM_TICKS(2), .OL_OFF_TICKS(5), .OL_ON_TICKS(4),
      .BC_ARM_TICKS(3), .BC_OFF_TICKS(4)) i_dut (.*);
   lsc_lnb_model i_lnb (.*);
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic settle();
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   // Waits for output_enable (k 0) or current_clamp (k 1) to reach v.
   task automatic wait_lvl(input int k, input logic v);
      int i;
      for (i = 0; i < 400 && (k == 0 ? output_enable : current_clamp) !== v; i++) @(posedge clk_sys) #1;
      if ((k == 0 ? output_enable : current_clamp) !== v) begin
         fail_count++;
         tally_and_finish();
      end
   endtask
   task automatic toggles();
      logic p;
      n = 0;
      settle();
      p = tone_out;
      repeat (100) begin
         @(posedge clk_sys);
         #1 if (tone_out !== p) n++;
         p = tone_out;
      end
   endtask
   task automatic t_regs();
      for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
      wr(3, 8'h13);
      rd(3, 8'h13);
      wr(2, 8'h1b);
      rd(2, 8'h1b);
      wr(1, 8'h18);
      rd(1, 8'h18);
      wr(0, 8'hff);
      rd(0, 8'h00);
   endtask
   task automatic t_select();
      logic [3:0] i;
      for (int j = 0; j < 16; j++) begin
         i = j[3:0];
         wr(2, {3'h0, i[0], i[3], 1'h0, i[1:0]});
         range_select_pin <= i[2];
         wr(3, {3'h0, 1'b1, 2'h0, i[1:0]});
         settle();
         chk(vout_select, i[3] ? i[1:0] : {i[2], i[2] ? i[1] : i[0]});
         chk({limit_level, dyn_limit_mode}, {i[1:0], ~i[0]});
      end
      wr(3, 8'h00);
      settle();
      chk({converter_enable, output_enable}, 2'b00);
   endtask
   task automatic t_tone();
      wr(2, 8'h10);
      wr(3, 8'h10);
      wr(1, 8'h10);
      toggles();
      chk(n > 0, 1);
      wr(1, 8'h00);
      toggles();
      chk(n, 0);
      @(posedge clk_sys) ext_modulation_input <= 1'b1;
      toggles();
      chk(n > 0, 1);
      wr(1, 8'h08);
      settle();
      chk(tone_out, 1);
      @(posedge clk_sys) ext_modulation_input <= 1'b0;
      settle();
      chk(tone_out, 0);
      transmit_threshold_select <= 1'b1;
      lnb_tone <= 1'b1;
      settle();
      chk({detector_tx_threshold, tone_detect_out_n_oe, tone_detect_out_n_o}, 3'b110);
      transmit_threshold_select <= 1'b0;
      lnb_tone <= 1'b0;
      settle();
      chk({detector_tx_threshold, tone_detect_out_n_oe}, 2'b00);
   endtask
   task automatic t_overload();
      wr(1, 8'h00);
      wr(2, 8'h00);
      @(posedge clk_sys) short_load <= 1'b1;
      wait_lvl(0, 0);
      rd(0, 8'h02);
      chk(fault_out_n_oe, 1);
      wait_lvl(1, 1);
      wait_lvl(0, 0);
      @(posedge clk_sys) short_load <= 1'b0;
      wait_lvl(1, 1);
      wait_lvl(1, 0);
      rd(0, 8'h00);
      @(posedge clk_sys) back_feed <= 1'b1;
      wait_lvl(0, 0);
      rd(0, 8'h01);
      wait_lvl(0, 1);
      wait_lvl(0, 0);
      @(posedge clk_sys) softstart_done <= 1'b1;
      @(posedge clk_sys) softstart_done <= 1'b0;
      rd(0, 8'h00);
      back_feed <= 1'b0;
      repeat (60) @(posedge clk_sys);
      rd(0, 8'h00);
      wr(2, 8'h10);
      short_load <= 1'b1;
      settle();
      rd(0, 8'h02);
      short_load <= 1'b0;
      settle();
      rd(0, 8'h00);
   endtask
   task automatic t_thermal();
      @(posedge clk_sys) temp_above_150 <= 1'b1;
      @(posedge clk_sys) temp_above_150 <= 1'b0;
      settle();
      chk({converter_enable, output_enable, fault_out_n_oe}, 3'b001);
      rd(0, 8'h10);
      rd(3, 8'h00);
      @(posedge clk_sys) temp_below_130 <= 1'b1;
      @(posedge clk_sys) temp_below_130 <= 1'b0;
      rd(0, 8'h00);
      wr(3, 8'h10);
      settle();
      chk(converter_enable, 1);
   endtask
   // Counts converter clock enable pulses over 40 cycles.
   task automatic clk_pulses(input logic [7:0] exp);
      n = 0;
      repeat (40) begin
         @(posedge clk_sys);
         #1 if (converter_clk_en === 1'b1) n++;
      end
      chk(n[7:0], exp);
   endtask
   task automatic t_pins();
      cable_open <= 1'b1;
      vout_out_of_range <= 1'b1;
      settle();
      rd(0, 8'h0c);
      chk({fault_out_n_oe, fault_out_n_o}, 2'b00);
      cable_open <= 1'b0;
      vout_out_of_range <= 1'b0;
      bus_reset <= 1'b1;
      settle();
      chk({fault_out_n_oe, fault_out_n_o}, 2'b10);
      bus_reset <= 1'b0;
      power_ok <= 1'b0;
      settle();
      chk({converter_enable, output_enable, fault_out_n_oe}, 3'b001);
      clk_pulses(8'h00);
      power_ok <= 1'b1;
      settle();
      clk_pulses(8'h0a);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      t_regs();
      t_select();
      t_tone();
      t_overload();
      t_thermal();
      t_pins();
      tally_and_finish();
   end
endmodule // lsc_supply_ctrl_tb
